// [design/char_display_instruction_decoder.sv]
// Instruction interpreter, text and glyph memories and scan path of a 2x20 character display.
// Notes on behaviour
// - Eight user glyphs of 5x8 dots, one lights.
// - Glyph addresses span 00H to 3FH only.
// - Glyph memory keeps and returns low five bits.
// - Codes 00H-0FH select glyphs, bit 3 ignored.
// - Glyph address is code[2:0] then dot row.
// - Clear fills text with 20H, counter to 00H.
// - Clear unshifts view, sets count-up, keeps glyphs.
// - Home zeroes counter and unshifts, memories kept.
// - Count-down: decrement; auto-shift moves view right.
// - Count-up: increment; auto-shift moves view left.
// - Auto-shift only on text writes, never otherwise.
// - Panel-on bit blanks or shows the text.
// - Underline bit shows cursor on eighth dot row.
// - Flash bit alternates cursor cell with full block.
// - Option instructions touch only their option bits.
// - Shift instruction steps counter, no memory access.
// - Shift encoding selects direction and view move.
// - Shift instruction always leaves counter on text.
// - Bus-width bit picks four or eight bit transfers; the code only stores it in opts, every transfer is eight bit.
// - Two-row bit picks one or two lines.
// - Luminance bits select 100, 75, 50, 25 percent; the code only stores them in opts.
// - Glyph address set loads six bits, selects glyphs.
// - Text address set loads seven bits, selects text.
// - Counter read returns counter, busy flag zero.
// - Data write stores byte, then steps as configured.
`timescale 1ns/1ps
module char_display_instruction_decoder
   import char_display_pkg::*;
#(
   parameter int BLINK_HALF_CYCLES = BLINK_HALF_CYC
) (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire host_xfer_t xfer,
   input  wire logic       scan_line,
   input  wire logic [4:0] scan_col,
   input  wire logic [2:0] scan_row,
   output logic [7:0]      rd_data,
   output logic            rd_valid,
   output opts_t           opts,
   output logic [6:0]      position_counter,
   output logic            glyph_mode,
   output logic [5:0]      view_offset,
   output logic            blink_phase,
   output logic [7:0]      scan_code,
   output logic [4:0]      scan_dots
);

   ////////////////////////////////////////////////////////////////////////////////
   // Decode and stepping helpers.

   function automatic op_t decode_op(input logic cmd_or_data_sel, input logic rnw,
                                     input logic [7:0] d);
      if (cmd_or_data_sel) begin
         return rnw ? OP_DATA_RD : OP_DATA_WR;
      end else if (rnw) begin
         return OP_CNT_READ;
      end else if (d[7]) begin
         return OP_TEXT_ADDR;
      end else if (d[6]) begin
         return OP_GLYPH_ADDR;
      end else if (d[5]) begin
         return OP_FUNC;
      end else if (d[4]) begin
         return OP_SHIFT;
      end else if (d[3]) begin
         return OP_CTRL;
      end else if (d[2]) begin
         return OP_ENTRY;
      end else if (d[1]) begin
         return OP_HOME;
      end else if (d[0]) begin
         return OP_CLEAR;
      end
      return OP_NONE;
   endfunction : decode_op

   // Text addresses wrap across the two line windows, skipping the unused gap.
   function automatic logic [6:0] text_step(input logic [6:0] a, input logic up);
      if (up) begin
         if (a == TEXT_LINE1_END) return TEXT_LINE2_BASE;
         if (a == TEXT_LINE2_END) return TEXT_HOME;
         return 7'(a + 7'h01);
      end
      if (a == TEXT_LINE2_BASE) return TEXT_LINE1_END;
      if (a == TEXT_HOME) return TEXT_LINE2_END;
      return 7'(a - 7'h01);
   endfunction : text_step

   function automatic logic [5:0] view_step(input logic [5:0] v, input logic left);
      if (left) return (v == VIEW_LAST) ? 6'h00 : 6'(v + 6'h01);
      return (v == 6'h00) ? VIEW_LAST : 6'(v - 6'h01);
   endfunction : view_step

   ////////////////////////////////////////////////////////////////////////////////
   // Memories and registered state.

   logic [7:0] text_mem  [128];
   logic [4:0] glyph_mem [64];

   opts_t      opts_reg,   opts_next;
   logic [6:0] pc_reg,     pc_next;
   logic       glyph_reg,  glyph_next;
   logic [5:0] view_reg,   view_next;
   logic [7:0] rd_reg,     rd_next;
   logic       rdv_reg,    rdv_next;
   logic       text_we,    glyph_we,   fill_text;
   op_t        cur_op;

   ////////////////////////////////////////////////////////////////////////////////
   // Instruction execution, one transfer per cycle.

   always_comb begin
      opts_next  = opts_reg;
      pc_next    = pc_reg;
      glyph_next = glyph_reg;
      view_next  = view_reg;
      rd_next    = rd_reg;
      rdv_next   = 1'b0;
      text_we    = 1'b0;
      glyph_we   = 1'b0;
      fill_text  = 1'b0;
      cur_op     = xfer.valid ? decode_op(xfer.cmd_or_data_sel, xfer.read_not_write,
                                          xfer.data) : OP_NONE;
      unique case (cur_op)
         OP_NONE: begin
         end
         OP_CLEAR: begin
            fill_text          = 1'b1;
            pc_next            = TEXT_HOME;
            glyph_next         = 1'b0;
            view_next          = 6'h00;
            opts_next.count_up = 1'b1;
         end
         OP_HOME: begin
            pc_next    = TEXT_HOME;
            glyph_next = 1'b0;
            view_next  = 6'h00;
         end
         OP_ENTRY: begin
            opts_next.count_up   = xfer.data[ENTRY_UP_BIT];
            opts_next.auto_shift = xfer.data[ENTRY_SHIFT_BIT];
         end
         OP_CTRL: begin
            opts_next.panel_on     = xfer.data[CTRL_PANEL_BIT];
            opts_next.underline_on = xfer.data[CTRL_UNDER_BIT];
            opts_next.flash_on     = xfer.data[CTRL_FLASH_BIT];
         end
         OP_SHIFT: begin
            // No memory strobe is raised here; only the counter and view move.
            pc_next    = text_step(pc_reg, xfer.data[SHIFT_RIGHT_BIT]);
            glyph_next = 1'b0;
            if (xfer.data[SHIFT_VIEW_BIT]) begin
               view_next = view_step(view_reg, !xfer.data[SHIFT_RIGHT_BIT]);
            end
         end
         OP_FUNC: begin
            opts_next.bus_width_eight = xfer.data[FUNC_WIDTH_BIT];
            opts_next.two_rows        = xfer.data[FUNC_ROWS_BIT];
            opts_next.luminance_high  = xfer.data[FUNC_LUM_HI_BIT];
            opts_next.luminance_low   = xfer.data[FUNC_LUM_LO_BIT];
         end
         OP_GLYPH_ADDR: begin
            pc_next    = {1'b0, xfer.data[5:0]};
            glyph_next = 1'b1;
         end
         OP_TEXT_ADDR: begin
            pc_next    = xfer.data[6:0];
            glyph_next = 1'b0;
         end
         OP_CNT_READ: begin
            rd_next  = {BUSY_FLAG_VAL, pc_reg};
            rdv_next = 1'b1;
         end
         OP_DATA_WR: begin
            if (glyph_reg) begin
               glyph_we = 1'b1;
               pc_next  = {1'b0, 6'(pc_reg[5:0] + (opts_reg.count_up ? 6'h01 : GLYPH_LAST))};
            end else begin
               text_we = 1'b1;
               pc_next = text_step(pc_reg, opts_reg.count_up);
               if (opts_reg.auto_shift) begin
                  view_next = view_step(view_reg, opts_reg.count_up);
               end
            end
         end
         OP_DATA_RD: begin
            rdv_next = 1'b1;
            if (glyph_reg) begin
               rd_next = {3'h0, glyph_mem[pc_reg[5:0]]};
               pc_next = {1'b0, 6'(pc_reg[5:0] + (opts_reg.count_up ? 6'h01 : GLYPH_LAST))};
            end else begin
               rd_next = text_mem[pc_reg];
               pc_next = text_step(pc_reg, opts_reg.count_up);
            end
         end
      endcase
   end

   // The busy flag never rises: all state lands at the edge that takes the byte.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         opts_reg  <= OPTS_RESET;
         pc_reg    <= TEXT_HOME;
         glyph_reg <= 1'b0;
         view_reg  <= 6'h00;
         rd_reg    <= 8'h00;
         rdv_reg   <= 1'b0;
      end else begin
         opts_reg  <= opts_next;
         pc_reg    <= pc_next;
         glyph_reg <= glyph_next;
         view_reg  <= view_next;
         rd_reg    <= rd_next;
         rdv_reg   <= rdv_next;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n || fill_text) begin
         for (int i = 0; i < 128; i++) begin
            text_mem[i] <= SPACE_CODE;
         end
      end else if (text_we) begin
         text_mem[pc_reg] <= xfer.data;
      end
   end

   // Glyph memory is untouched by reset and clear; only data writes land here.
   always_ff @(posedge mclk) begin
      if (glyph_we) begin
         glyph_mem[pc_reg[5:0]] <= xfer.data[4:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Blink divider: one enable pulse per half period toggles the phase.

   logic [31:0] blink_cnt_reg, blink_cnt_next;
   logic        blink_reg,     blink_next;

   always_comb begin
      blink_cnt_next = 32'(blink_cnt_reg + 32'h1);
      blink_next     = blink_reg;
      if (blink_cnt_reg == 32'(BLINK_HALF_CYCLES - 1)) begin
         blink_cnt_next = 32'h0;
         blink_next     = !blink_reg;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         blink_cnt_reg <= 32'h0;
         blink_reg     <= 1'b0;
      end else begin
         blink_cnt_reg <= blink_cnt_next;
         blink_reg     <= blink_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Scan path: visible cell to code and dot row, with cursor and blanking.

   logic [6:0] col_sum;
   logic [6:0] cell_addr;
   logic [7:0] cell_code;
   logic [4:0] dots_next;
   logic       at_cursor;

   always_comb begin
      col_sum = 7'({2'b00, scan_col} + {1'b0, view_reg});
      if (col_sum >= VIEW_SPAN) begin
         col_sum = 7'(col_sum - VIEW_SPAN);
      end
      cell_addr = (scan_line ? TEXT_LINE2_BASE : TEXT_HOME) | col_sum;
      cell_code = text_mem[cell_addr];
      at_cursor = !glyph_reg && (cell_addr == pc_reg);
      dots_next = DOTS_NONE;
      if (cell_code[7:4] == 4'h0) begin
         dots_next = glyph_mem[{cell_code[2:0], scan_row}];
      end
      if (at_cursor && opts_reg.flash_on && blink_reg) begin
         dots_next = DOTS_ALL;
      end else if (at_cursor && opts_reg.underline_on && scan_row == CURSOR_ROW) begin
         dots_next = DOTS_ALL;
      end
      if (!opts_reg.panel_on || (scan_line && !opts_reg.two_rows)) begin
         dots_next = DOTS_NONE;
      end
   end

   // Bit 3 of a user code plays no part in the glyph lookup above.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         scan_code <= SPACE_CODE;
         scan_dots <= DOTS_NONE;
      end else begin
         scan_code <= cell_code;
         scan_dots <= dots_next;
      end
   end

   assign rd_data          = rd_reg;
   assign rd_valid         = rdv_reg;
   assign opts             = opts_reg;
   assign position_counter = pc_reg;
   assign glyph_mode       = glyph_reg;
   assign view_offset      = view_reg;
   assign blink_phase      = blink_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions and cover points.

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_clear_home_pos: assert property (cur_op == OP_CLEAR |=>
      position_counter == TEXT_HOME && !glyph_mode && text_mem[$past(pc_reg)] == SPACE_CODE)
      else $error("clear did not home the counter or fill spaces");
   a_clear_entry_up: assert property (cur_op == OP_CLEAR |=>
      opts.count_up && view_offset == 6'h00)
      else $error("clear did not restore count-up and view");
   a_home_pos: assert property (cur_op == OP_HOME |=>
      position_counter == TEXT_HOME && view_offset == 6'h00)
      else $error("home did not reset counter and view");
   a_write_up_step: assert property (cur_op == OP_DATA_WR && !glyph_reg
      && opts_reg.count_up && pc_reg < TEXT_LINE1_END
      |=> position_counter == 7'($past(pc_reg) + 7'h01))
      else $error("write did not increment the counter");
   a_write_dn_shift: assert property (cur_op == OP_DATA_WR && !glyph_reg
      && !opts_reg.count_up && opts_reg.auto_shift |=>
      view_offset == view_step($past(view_reg), 1'b0))
      else $error("count-down write did not move view right");
   a_read_no_shift: assert property (cur_op == OP_DATA_RD |=>
      view_offset == $past(view_reg))
      else $error("read moved the view");
   a_opts_keep_pc: assert property (cur_op inside {OP_ENTRY, OP_CTRL, OP_FUNC} |=>
      $stable(position_counter) && $stable(glyph_mode))
      else $error("option instruction moved the counter");
   a_shift_to_text: assert property (cur_op == OP_SHIFT |=> !glyph_mode)
      else $error("shift left the counter on glyph memory");
   a_glyph_load: assert property (cur_op == OP_GLYPH_ADDR |=>
      glyph_mode && position_counter == {1'b0, $past(xfer.data[5:0])})
      else $error("glyph address not loaded");
   a_text_load: assert property (cur_op == OP_TEXT_ADDR |=>
      !glyph_mode && position_counter == $past(xfer.data[6:0]))
      else $error("text address not loaded");
   a_count_read_val: assert property (cur_op == OP_CNT_READ |=>
      rd_valid && rd_data == {1'b0, $past(pc_reg)} ##1 (!rd_valid || $past(xfer.valid)))
      else $error("counter read returned a wrong value");
   a_panel_blank: assert property (!opts.panel_on |=> scan_dots == DOTS_NONE)
      else $error("blanked panel shows dots");

   c_clear_seen: cover property (cur_op == OP_CLEAR);
   c_glyph_write: cover property (cur_op == OP_GLYPH_ADDR ##1 cur_op == OP_DATA_WR);
   c_shift_view: cover property (cur_op == OP_SHIFT && xfer.data[SHIFT_VIEW_BIT]);
   c_blink_toggle: cover property (opts.flash_on && $changed(blink_phase));

endmodule : char_display_instruction_decoder

// [design/char_display_pkg.sv]
// Shared constants, codes and carriers for the character display instruction decoder.
package char_display_pkg;

   localparam int         CLK_PERIOD_NS    = 10;
   localparam int         BLINK_HALF_MS    = 500;
   localparam int         BLINK_HALF_CYC   = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;

   localparam logic [7:0] SPACE_CODE       = 8'h20;
   localparam logic [6:0] TEXT_HOME        = 7'h00;
   localparam logic [6:0] TEXT_LINE1_END   = 7'h27;
   localparam logic [6:0] TEXT_LINE2_BASE  = 7'h40;
   localparam logic [6:0] TEXT_LINE2_END   = 7'h67;
   localparam logic [5:0] GLYPH_LAST       = 6'h3F;
   localparam logic [5:0] VIEW_LAST        = 6'h27;
   localparam logic [6:0] VIEW_SPAN        = 7'h28;
   localparam logic [2:0] CURSOR_ROW       = 3'h7;
   localparam logic [4:0] DOTS_ALL         = 5'h1F;
   localparam logic [4:0] DOTS_NONE        = 5'h00;
   localparam logic       BUSY_FLAG_VAL    = 1'b0;

   localparam int         ENTRY_UP_BIT     = 1;
   localparam int         ENTRY_SHIFT_BIT  = 0;
   localparam int         CTRL_PANEL_BIT   = 2;
   localparam int         CTRL_UNDER_BIT   = 1;
   localparam int         CTRL_FLASH_BIT   = 0;
   localparam int         SHIFT_VIEW_BIT   = 3;
   localparam int         SHIFT_RIGHT_BIT  = 2;
   localparam int         FUNC_WIDTH_BIT   = 4;
   localparam int         FUNC_ROWS_BIT    = 3;
   localparam int         FUNC_LUM_HI_BIT  = 1;
   localparam int         FUNC_LUM_LO_BIT  = 0;

   typedef enum logic [3:0] {
      OP_NONE       = 4'b0000,
      OP_CLEAR      = 4'b0001,
      OP_HOME       = 4'b0010,
      OP_ENTRY      = 4'b0011,
      OP_CTRL       = 4'b0100,
      OP_SHIFT      = 4'b0101,
      OP_FUNC       = 4'b0110,
      OP_GLYPH_ADDR = 4'b0111,
      OP_TEXT_ADDR  = 4'b1000,
      OP_CNT_READ   = 4'b1001,
      OP_DATA_WR    = 4'b1010,
      OP_DATA_RD    = 4'b1011
   } op_t;

   typedef struct packed {
      logic       valid;
      logic       cmd_or_data_sel;
      logic       read_not_write;
      logic [7:0] data;
   } host_xfer_t;

   typedef struct packed {
      logic panel_on;
      logic underline_on;
      logic flash_on;
      logic count_up;
      logic auto_shift;
      logic bus_width_eight;
      logic two_rows;
      logic luminance_high;
      logic luminance_low;
   } opts_t;

   localparam opts_t OPTS_RESET = '{panel_on: 1'b0, underline_on: 1'b0, flash_on: 1'b0,
                                    count_up: 1'b1, auto_shift: 1'b0, bus_width_eight: 1'b1,
                                    two_rows: 1'b1, luminance_high: 1'b0,
                                    luminance_low: 1'b0};

endpackage : char_display_pkg

// [sim/host_model.sv]
// Host processor model that presents instruction and data bytes to the decoder.
`timescale 1ns/1ps
module host_model
   import char_display_pkg::*;
(
   input  wire logic mclk,
   output host_xfer_t xfer
);
   initial begin
      xfer = '0;
   end

   // One byte per call, held from just after one edge until the next send or idle call; calls may follow back to back.
   task automatic send(input logic sel, input logic rnw, input logic [7:0] d);
      @(posedge mclk);
      xfer <= '{valid: 1'b1, cmd_or_data_sel: sel, read_not_write: rnw, data: d};
   endtask : send

   // Released lines show a pattern that changes on every call so stale bytes never look held.
   task automatic idle();
      @(posedge mclk);
      xfer <= '{valid: 1'b0, cmd_or_data_sel: ~xfer.cmd_or_data_sel,
                read_not_write: ~xfer.read_not_write, data: ~xfer.data};
   endtask : idle
endmodule : host_model

// [sim/test_char_display_instruction_decoder.sv]
// Self-checking bench for the character display instruction decoder.
`timescale 1ns/1ps
module test_char_display_instruction_decoder
   import char_display_pkg::*;
();
   localparam int BLINK = 8;
   logic        mclk;
   logic        rst_n;
   host_xfer_t  xfer;
   logic        scan_line;
   logic [4:0]  scan_col;
   logic [2:0]  scan_row;
   logic [7:0]  rd_data;
   logic        rd_valid;
   opts_t       opts;
   logic [6:0]  position_counter;
   logic        glyph_mode;
   logic [5:0]  view_offset;
   logic        blink_phase;
   logic [7:0]  scan_code;
   logic [4:0]  scan_dots;
   logic [7:0]  exp_q[$];
   int          n_fail;
   int          num_checks;
   int          k;
   logic [10:0] r;
   logic [6:0]  cnt_e;
   logic [5:0]  view_e;

   char_display_instruction_decoder #(.BLINK_HALF_CYCLES(BLINK))
      i_char_display_instruction_decoder (
      .mclk(mclk), .rst_n(rst_n), .xfer(xfer), .scan_line(scan_line), .scan_col(scan_col),
      .scan_row(scan_row), .rd_data(rd_data), .rd_valid(rd_valid), .opts(opts),
      .position_counter(position_counter), .glyph_mode(glyph_mode), .view_offset(view_offset),
      .blink_phase(blink_phase), .scan_code(scan_code), .scan_dots(scan_dots));
   host_model i_host_model (.mclk(mclk), .xfer(xfer));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check
   task automatic cmd(input logic [7:0] d);
      i_host_model.send(1'b0, 1'b0, d);
   endtask : cmd
   task automatic wr(input logic [7:0] d);
      i_host_model.send(1'b1, 1'b0, d);
   endtask : wr
   task automatic rd(input logic sel, input logic [7:0] e);
      exp_q.push_back(e);
      i_host_model.send(sel, 1'b1, 8'($urandom));
   endtask : rd
   task automatic look();
      i_host_model.idle();
      @(negedge mclk);
   endtask : look
   task automatic scan(input logic ln, input logic [4:0] col, input logic [2:0] row);
      @(posedge mclk);
      scan_line <= ln;
      scan_col  <= col;
      scan_row  <= row;
      @(posedge mclk);
      @(negedge mclk);
   endtask : scan
   task automatic wait_flip(output int n);
      logic b;
      b = blink_phase;
      n = 0;
      while (blink_phase === b && n < 40) begin
         @(negedge mclk);
         n++;
      end
   endtask : wait_flip
   task automatic close_out();
      if (exp_q.size() != 0) n_fail++;
      $display("checks=%0d mismatches=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out

   // Every read answer is matched against the oldest expectation noted by the driver.
   always @(posedge mclk) begin
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) check(16'(rd_data), 16'hFFFF);
         else check(16'(rd_data), 16'(exp_q.pop_front()));
      end
   end

   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      n_fail = 0; num_checks = 0; rst_n = 1'b0;
      scan_line = 1'b0; scan_col = 5'h00; scan_row = 3'h0;
      void'($urandom(84856));
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      @(negedge mclk);
      check(16'(opts), 16'(OPTS_RESET));
      check(16'(position_counter), 16'h0000);
      rd(1'b1, 8'h20);
      cmd(8'hA7); wr(8'h41); rd(1'b0, 8'h40);
      cmd(8'hA7); rd(1'b1, 8'h41);
      cmd(8'h04); rd(1'b0, 8'h40);
      wr(8'h42); rd(1'b0, 8'h27);
      cmd(8'hC0); rd(1'b1, 8'h42);
      r = 11'($urandom);
      cmd(8'h90); cmd(8'h05); wr(r[7:0]); look();
      check(16'(view_offset), 16'h0027);
      cmd(8'h07); wr(8'($urandom)); look();
      check(16'(view_offset), 16'h0000);
      rd(1'b1, r[7:0]);
      cmd(8'h40); wr(8'($urandom)); look();
      check(16'(view_offset), 16'h0000);
      cmd(8'h06); cmd(8'h7F); look();
      check(16'({glyph_mode, position_counter}), 16'h00BF);
      wr(8'hFF); rd(1'b0, 8'h00);
      cmd(8'h7F); rd(1'b1, 8'h1F);
      cmd(8'h5A); wr(8'hF5); cmd(8'h80); wr(8'h0B); cmd(8'h0C);
      scan(1'b0, 5'h00, 3'h2);
      check(16'({scan_code, 3'h0, scan_dots}), 16'h0B15);
      cmd(8'h0E); scan(1'b0, 5'h01, 3'h7);
      check(16'(scan_dots), 16'h001F);
      cmd(8'h08); scan(1'b0, 5'h00, 3'h2);
      check(16'(scan_dots), 16'h0000);
      cmd(8'h0D); look();
      wait_flip(k); wait_flip(k);
      check(16'(k), 16'(BLINK));
      if (blink_phase !== 1'b1) wait_flip(k);
      scan(1'b0, 5'h01, 3'h0);
      check(16'(scan_dots), 16'h001F);
      cmd(8'h45); cnt_e = 7'h05; view_e = 6'h00;
      for (int i = 0; i < 4; i++) begin
         cmd(8'h10 | 8'(i << 2) | 8'($urandom % 4)); look();
         cnt_e  = i[0] ? cnt_e + 7'h01 : cnt_e - 7'h01;
         view_e = i[1] ? (i[0] ? view_e - 6'h01 : view_e + 6'h01) : view_e;
         check(16'({glyph_mode, position_counter}), 16'(cnt_e));
         check(16'(view_offset), 16'(view_e));
      end
      cmd(8'h18); cmd(8'h03); look();
      check(16'({view_offset, position_counter}), 16'h0000);
      rd(1'b1, 8'h0B);
      cmd(8'h04); cmd(8'h1C); cmd(8'h01); look();
      check(16'({view_offset, opts.count_up, position_counter}), 16'h0080);
      rd(1'b1, 8'h20); cmd(8'hA7); rd(1'b1, 8'h20);
      cmd(8'h5A); rd(1'b1, 8'h15);
      cmd(8'h80); cmd(8'h00); look();
      // Panel and flash are still on from the blink test; count-up was restored by clear.
      check(16'({opts, position_counter}), 16'hB600);
      for (int i = 0; i < 8; i++) begin
         r = 11'($urandom);
         // The host always keeps two lines selected.
         cmd({3'b001, r[4], 1'b1, r[5], r[1:0]});
         cmd({5'b00001, r[8:6]}); cmd({6'b000001, r[10:9]}); look();
         check(16'(opts), 16'({r[8:6], r[10:9], r[4], 1'b1, r[1:0]}));
         check(16'(position_counter), 16'h0000);
      end
      repeat (3) look();
      close_out();
   end
endmodule : test_char_display_instruction_decoder
